// ==== core/ebp_pkg.sv ====
// package: constants and types for the eeprom block protection logic
package ebp_pkg;
   localparam int unsigned NUM_BLOCKS      = 4;
   localparam int unsigned BLK_W           = 2;
   localparam int unsigned PW_WORDS        = 3;
   localparam logic [31:0] PW_INVALID      = 32'hffffffff;
   // register offsets (byte addresses)
   localparam logic [7:0]  REG_BLOCK       = 8'h00;
   localparam logic [7:0]  REG_PROT        = 8'h04;
   localparam logic [7:0]  REG_PW          = 8'h08;
   localparam logic [7:0]  REG_UNLOCK      = 8'h0c;
   localparam logic [7:0]  REG_CMD         = 8'h10;
   localparam logic [7:0]  REG_STATUS      = 8'h14;
   localparam logic [7:0]  REG_INT_RAW     = 8'h18;
   localparam logic [7:0]  REG_INT_MASK    = 8'h1c;
   localparam logic [7:0]  REG_INT_MSK_ST  = 8'h20;
   localparam logic [7:0]  REG_INIT        = 8'h24;
   localparam logic [7:0]  REG_CHECK       = 8'h28;
   // protection field
   localparam int unsigned PROT_MODE_LSB   = 0;
   localparam int unsigned PROT_PRIV_BIT   = 3;
   localparam logic [1:0]  MODE_RW_LRO     = 2'h0;
   localparam logic [1:0]  MODE_NA_URW     = 2'h1;
   localparam logic [1:0]  MODE_RO_LNA     = 2'h2;
   localparam logic [3:0]  PROT_RESET      = 4'h0;
   // command bits
   localparam int unsigned CMD_LOCK_BIT    = 0;
   localparam int unsigned CMD_HIDE_BIT    = 1;
   localparam int unsigned CMD_COMMIT_BIT  = 2;
   localparam int unsigned CMD_PROG_BIT    = 3;
   // status bits
   localparam int unsigned ST_WRBUSY_BIT   = 0;
   localparam int unsigned ST_NOPERM_BIT   = 1;
   localparam int unsigned ST_COPY_BIT     = 2;
   localparam int unsigned ST_ERASE_BIT    = 3;
   localparam int unsigned ST_WORK_BIT     = 4;
   // check register: bit0 set checks write, bit0 clear checks read, bits 1:0 result
   localparam int unsigned CHK_WR_BIT      = 0;
   // engine phase lengths in cycles
   localparam logic [7:0]  COPY_CYCLES     = 8'h10;
   localparam logic [7:0]  ERASE_CYCLES    = 8'h08;
   localparam logic [7:0]  WRITE_CYCLES    = 8'h10;
   typedef enum logic [1:0] {ENG_IDLE, ENG_COPY, ENG_ERASE, ENG_WRITE} ebp_eng_t;
endpackage : ebp_pkg

// ==== core/ebp_engine.sv ====
// programming engine sequencer: copy, erase and write phases
`timescale 1ns/100ps
`default_nettype none
module ebp_engine
   import ebp_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic start,
   output logic      busy,
   output logic      copying,
   output logic      erasing,
   output logic      done
);
   ebp_eng_t   state_q, state_d;
   logic [7:0] cnt_q, cnt_d;
   logic       last;

   assign last    = (cnt_q == 8'h01);
   assign busy    = (state_q != ENG_IDLE);
   assign copying = (state_q == ENG_COPY);
   assign erasing = (state_q == ENG_ERASE);
   assign done    = (state_q == ENG_WRITE) && last;

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q - 8'h01;
      unique case (state_q)
         ENG_IDLE: begin
            cnt_d = cnt_q;
            if (start) begin
               state_d = ENG_COPY;
               cnt_d   = COPY_CYCLES;
            end
         end
         ENG_COPY: if (last) begin
            state_d = ENG_ERASE;
            cnt_d   = ERASE_CYCLES;
         end
         ENG_ERASE: if (last) begin
            state_d = ENG_WRITE;
            cnt_d   = WRITE_CYCLES;
         end
         ENG_WRITE: if (last) begin
            state_d = ENG_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ENG_IDLE;
         cnt_q   <= 8'h00;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end
endmodule : ebp_engine
`default_nettype wire

// ==== core/ebp_top.sv ====
// eeprom block protection: access checks, passwords, status and program interrupt
`timescale 1ns/100ps
`default_nettype none
module ebp_top
   import ebp_pkg::*;
#(
   parameter int unsigned NBLK = NUM_BLOCKS
)(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   input  wire logic        priv,
   input  wire logic        init_fail,
   output logic [31:0]      rdata,
   output logic             irq
);
   import ebp_pkg::*;

   localparam int unsigned BW = $clog2(NBLK);

   logic [BW-1:0]  sel_q;
   logic [3:0]     prot_q   [NBLK];
   logic [31:0]    pw_q     [NBLK][PW_WORDS];
   logic [31:0]    stage_q  [PW_WORDS];
   logic [1:0]     stage_n_q;
   logic [NBLK-1:0] pw_set_q, locked_q, hidden_q, prot_set_q;
   logic           noperm_q, wrbusy_q, int_raw_q, int_en_q, init_err_q, init_done_q;
   logic [1:0]     chk_res_q;
   logic [31:0]    rdata_q;
   logic           irq_q;
   logic           eng_busy, eng_copy, eng_erase, eng_done;

   // per-block effective protection, used only by the check port; register gating uses reg_ok
   function automatic logic [1:0] allow(input logic [3:0] p, input logic has_pw, input logic lk,
                                         input logic pv, input logic hid);
      logic r, w;
      r = 1'b0;
      w = 1'b0;
      unique case (p[1:0])
         MODE_RW_LRO: begin r = 1'b1; w = !(has_pw && lk); end
         MODE_NA_URW: begin r = has_pw && !lk; w = has_pw && !lk; end
         default:     begin r = !(has_pw && lk); w = 1'b0; end
      endcase
      if ((p[PROT_PRIV_BIT] && !pv) || hid) begin
         r = 1'b0;
         w = 1'b0;
      end
      return {w, r};
   endfunction : allow

   wire          g0_lock  = pw_set_q[0] && locked_q[0];
   wire          sel_nz   = (sel_q != '0);
   // blocks above 0 combine their flags with block 0
   wire [3:0]    prot_eff = sel_nz ? (prot_q[sel_q] | prot_q[0]) : prot_q[sel_q];
   wire [1:0]    acc_raw  = allow(prot_eff, pw_set_q[sel_q], locked_q[sel_q], priv, hidden_q[sel_q]);
   wire          gated    = sel_nz && g0_lock;
   wire [1:0]    acc      = gated ? 2'b00 : acc_raw;
   wire          reg_ok   = !gated && !hidden_q[sel_q];
   wire          eng_ok   = !eng_busy;
   wire [31:0]   wd       = wdata;
   wire          pw_word_ok = (wd != PW_INVALID);
   // unused slots hold all ones, so a short unlock never matches a longer password
   wire          pw_match = (stage_n_q != 2'h0) && (stage_q[0] == pw_q[sel_q][0]) &&
                            (pw_q[sel_q][1] == ((stage_n_q > 2'h1) ? stage_q[1] : PW_INVALID)) &&
                            (pw_q[sel_q][2] == ((stage_n_q > 2'h2) ? stage_q[2] : PW_INVALID));
   wire          commit_ok = reg_ok && eng_ok && !pw_set_q[sel_q] && (stage_n_q != 2'h0);
   wire          is_wr_chk = wr && addr == REG_CHECK && wd[CHK_WR_BIT];
   wire          is_rd_chk = wr && addr == REG_CHECK && !wd[CHK_WR_BIT];
   wire          do_prog  = wr && addr == REG_CMD && wd[CMD_PROG_BIT] && eng_ok;
   wire          do_prot  = wr && addr == REG_PROT && reg_ok && eng_ok && !prot_set_q[sel_q];
   wire          do_commit = wr && addr == REG_CMD && wd[CMD_COMMIT_BIT];
   wire          deny_wr  = (is_wr_chk && !acc[1]) || (do_commit && !commit_ok) ||
                            (wr && addr == REG_PROT && !do_prot);
   wire          rd_busy  = is_rd_chk && eng_busy;
   wire          blk_shut = pw_set_q[sel_q] && locked_q[sel_q];
   wire          blk_open = pw_set_q[sel_q] && !locked_q[sel_q];
   wire          chk_open = wr && addr == REG_CHECK && !gated && !hidden_q[sel_q] &&
                            (priv || !prot_eff[PROT_PRIV_BIT]);

   ebp_engine u_engine (
      .clk     (clk),
      .rst_n   (rst_n),
      .start   (do_prog || (do_commit && commit_ok) || do_prot),
      .busy    (eng_busy),
      .copying (eng_copy),
      .erasing (eng_erase),
      .done    (eng_done)
   );

   wire [31:0] status_w = (32'(wrbusy_q) << ST_WRBUSY_BIT) | (32'(noperm_q) << ST_NOPERM_BIT) |
                          (32'(eng_copy) << ST_COPY_BIT) | (32'(eng_erase) << ST_ERASE_BIT) |
                          (32'(eng_busy) << ST_WORK_BIT);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_q     <= '0;
         stage_n_q <= 2'h0;
         chk_res_q <= 2'h0;
         noperm_q  <= 1'b0;
         wrbusy_q  <= 1'b0;
         int_raw_q <= 1'b0;
         int_en_q  <= 1'b0;
         init_err_q  <= 1'b0;
         init_done_q <= 1'b0;
         rdata_q   <= 32'h0;
         irq_q     <= 1'b0;
         pw_set_q  <= '0;
         locked_q  <= '0;
         hidden_q  <= '0;
         prot_set_q <= '0;
         for (int i = 0; i < int'(PW_WORDS); i++) stage_q[i] <= 32'h0;
         for (int b = 0; b < int'(NBLK); b++) begin
            prot_q[b] <= PROT_RESET;
            for (int i = 0; i < int'(PW_WORDS); i++) pw_q[b][i] <= 32'h0;
         end
      end else begin
         // init outcome latched once after reset release
         if (!init_done_q) begin
            init_done_q <= 1'b1;
            init_err_q  <= init_fail;
         end
         if (wr && addr == REG_BLOCK) sel_q <= wd[BW-1:0];
         if (wr && addr == REG_PW && reg_ok) begin
            if (pw_word_ok && stage_n_q < 2'(PW_WORDS)) begin
               stage_q[stage_n_q] <= wd;
               stage_n_q <= stage_n_q + 2'h1;
            end
         end
         if (do_prot) begin
            prot_q[sel_q]     <= wd[3:0];
            prot_set_q[sel_q] <= 1'b1;
         end
         if (do_commit) begin
            stage_n_q <= 2'h0;
            if (commit_ok) begin
               for (int i = 0; i < int'(PW_WORDS); i++)
                  pw_q[sel_q][i] <= (i < int'(stage_n_q)) ? stage_q[i] : PW_INVALID;
               pw_set_q[sel_q] <= 1'b1;
               locked_q[sel_q] <= 1'b0;
            end
         end
         if (wr && addr == REG_UNLOCK && !gated) begin
            stage_n_q <= 2'h0;
            if (pw_set_q[sel_q] && pw_match) locked_q[sel_q] <= 1'b0;
         end
         if (wr && addr == REG_CMD && wd[CMD_LOCK_BIT] && (reg_ok || sel_q == '0)) begin
            if (sel_q == '0) locked_q <= pw_set_q; // locking block 0 relocks all passworded blocks
            else locked_q[sel_q] <= pw_set_q[sel_q];
         end
         if (wr && addr == REG_CMD && wd[CMD_HIDE_BIT] && sel_nz && reg_ok) hidden_q[sel_q] <= 1'b1;
         if (wr && addr == REG_CHECK) chk_res_q <= acc;
         // flags: set wins over a same-cycle clear by a status or REG_INT_RAW write
         if (deny_wr) noperm_q <= 1'b1;
         else if (wr && addr == REG_STATUS && wd[ST_NOPERM_BIT]) noperm_q <= 1'b0;
         if (rd_busy) wrbusy_q <= 1'b1;
         else if (wr && addr == REG_STATUS && wd[ST_WRBUSY_BIT]) wrbusy_q <= 1'b0;
         if (eng_done) int_raw_q <= 1'b1;
         else if (wr && addr == REG_INT_RAW && wd[0]) int_raw_q <= 1'b0;
         if (wr && addr == REG_INT_MASK) int_en_q <= wd[0];
         irq_q <= int_raw_q && int_en_q;
         if (rd) begin
            unique case (addr)
               REG_BLOCK:      rdata_q <= 32'(sel_q);
               REG_PROT:       rdata_q <= reg_ok ? 32'(prot_q[sel_q]) : 32'h0;
               REG_UNLOCK:     rdata_q <= 32'(!(pw_set_q[sel_q] && locked_q[sel_q]));
               REG_STATUS:     rdata_q <= status_w;
               REG_INT_RAW:    rdata_q <= 32'(int_raw_q);
               REG_INT_MASK:   rdata_q <= 32'(int_en_q);
               REG_INT_MSK_ST: rdata_q <= 32'(int_raw_q && int_en_q);
               REG_INIT:       rdata_q <= 32'(init_err_q);
               REG_CHECK:      rdata_q <= 32'(chk_res_q);
               default:        rdata_q <= 32'h0;
            endcase
         end else begin
            rdata_q <= 32'h0;
         end
      end
   end

   assign rdata = rdata_q;
   assign irq   = irq_q;

   property p_gate0;
      @(posedge clk) disable iff (!rst_n) (wr && addr == REG_CHECK && sel_nz && g0_lock) |=> chk_res_q == 2'b00;
   endproperty
   a_gate0: assert property (p_gate0) else $error("locked block 0 did not gate access");
   property p_deny;
      @(posedge clk) disable iff (!rst_n) (is_wr_chk && !acc[1]) |=> noperm_q;
   endproperty
   a_deny: assert property (p_deny) else $error("refused write did not set denied flag");
   property p_wrbusy;
      @(posedge clk) disable iff (!rst_n) rd_busy |=> wrbusy_q;
   endproperty
   a_wrbusy: assert property (p_wrbusy) else $error("read during write not flagged");
   property p_hide;
      @(posedge clk) disable iff (!rst_n) (hidden_q[sel_q] && is_rd_chk) |=> chk_res_q == 2'b00;
   endproperty
   a_hide: assert property (p_hide) else $error("hidden block accessible");
   property p_priv;
      @(posedge clk) disable iff (!rst_n) (wr && addr == REG_CHECK && prot_eff[PROT_PRIV_BIT] && !priv)
         |=> chk_res_q == 2'b00;
   endproperty
   a_priv: assert property (p_priv) else $error("user access passed privileged block");
   property p_nomatch;
      @(posedge clk) disable iff (!rst_n) (wr && addr == REG_UNLOCK && !pw_match && locked_q[sel_q])
         |=> locked_q[$past(sel_q)];
   endproperty
   a_nomatch: assert property (p_nomatch) else $error("wrong password unlocked block");
   property p_irq;
      @(posedge clk) disable iff (!rst_n) (eng_done && int_en_q) |=> ##1 irq;
   endproperty
   a_irq: assert property (p_irq) else $error("program interrupt missing");
   property p_work;
      @(posedge clk) disable iff (!rst_n) (rd && addr == REG_STATUS && eng_busy) |=> rdata[ST_WORK_BIT];
   endproperty
   a_work: assert property (p_work) else $error("working bit not shown");
   property p_mode_rw;
      @(posedge clk) disable iff (!rst_n) (chk_open && prot_eff[1:0] == MODE_RW_LRO)
         |=> chk_res_q[0] && (chk_res_q[1] == !$past(blk_shut));
   endproperty
   a_mode_rw: assert property (p_mode_rw) else $error("rw/locked-ro policy wrong");
   property p_mode_na;
      @(posedge clk) disable iff (!rst_n) (chk_open && prot_eff[1:0] == MODE_NA_URW)
         |=> chk_res_q == {2{$past(blk_open)}};
   endproperty
   a_mode_na: assert property (p_mode_na) else $error("noaccess/unlocked-rw policy wrong");
   property p_mode_ro;
      @(posedge clk) disable iff (!rst_n) (chk_open && prot_eff[1:0] == MODE_RO_LNA)
         |=> !chk_res_q[1] && (chk_res_q[0] == !$past(blk_shut));
   endproperty
   a_mode_ro: assert property (p_mode_ro) else $error("ro/locked-noaccess policy wrong");
   property p_or0;
      @(posedge clk) disable iff (!rst_n) (wr && addr == REG_CHECK && sel_nz && prot_q[0][1:0] == MODE_RO_LNA)
         |=> !chk_res_q[1];
   endproperty
   a_or0: assert property (p_or0) else $error("block 0 flags not combined");
   property p_unlock;
      @(posedge clk) disable iff (!rst_n) (wr && addr == REG_UNLOCK && !gated && pw_set_q[sel_q] && pw_match)
         |=> !locked_q[$past(sel_q)];
   endproperty
   a_unlock: assert property (p_unlock) else $error("matching password did not unlock");
   property p_pw_once;
      @(posedge clk) disable iff (!rst_n) (do_commit && pw_set_q[sel_q]) |=> noperm_q;
   endproperty
   a_pw_once: assert property (p_pw_once) else $error("second password not refused");
   property p_pw_skip;
      @(posedge clk) disable iff (!rst_n) (wr && addr == REG_PW && wdata == PW_INVALID)
         |=> stage_n_q == $past(stage_n_q);
   endproperty
   a_pw_skip: assert property (p_pw_skip) else $error("all-ones password word was staged");
   property p_init;
      @(posedge clk) disable iff (!rst_n) $rose(init_done_q) |-> init_err_q == $past(init_fail);
   endproperty
   a_init: assert property (p_init) else $error("init outcome not captured");
   property p_phase;
      @(posedge clk) disable iff (!rst_n) (rd && addr == REG_STATUS)
         |=> (rdata[ST_COPY_BIT] == $past(eng_copy)) && (rdata[ST_ERASE_BIT] == $past(eng_erase));
   endproperty
   a_phase: assert property (p_phase) else $error("copy or erase bit not shown");
   property p_busy_wr;
      @(posedge clk) disable iff (!rst_n) (eng_busy && wr && addr == REG_PROT) |=> noperm_q;
   endproperty
   a_busy_wr: assert property (p_busy_wr) else $error("write accepted while engine busy");
   property p_int_clr;
      @(posedge clk) disable iff (!rst_n) (wr && addr == REG_INT_RAW && wdata[0] && !eng_done)
         |=> !int_raw_q;
   endproperty
   a_int_clr: assert property (p_int_clr) else $error("program interrupt not cleared");
   property p_int_off;
      @(posedge clk) disable iff (!rst_n) !int_en_q |=> !irq;
   endproperty
   a_int_off: assert property (p_int_off) else $error("disabled interrupt raised");
   property p_hide_keep;
      @(posedge clk) disable iff (!rst_n) hidden_q[sel_q] |=> hidden_q[$past(sel_q)];
   endproperty
   a_hide_keep: assert property (p_hide_keep) else $error("hidden block came back");
   property p_sel;
      @(posedge clk) disable iff (!rst_n) (wr && addr == REG_BLOCK) |=> sel_q == $past(wdata[BW-1:0]);
   endproperty
   a_sel: assert property (p_sel) else $error("block select not taken");
   property p_gate_reg;
      @(posedge clk) disable iff (!rst_n) (rd && addr == REG_PROT && gated) |=> rdata == 32'h0;
   endproperty
   a_gate_reg: assert property (p_gate_reg) else $error("locked block 0 exposed block registers");
endmodule : ebp_top
`default_nettype wire

// ==== tb/ebp_host_model.sv ====
// bus master model driving the protection register port
`timescale 1ns/100ps
`default_nettype none
module ebp_host_model (
   input  wire logic        clk,
   output logic [7:0]       addr,
   output logic [31:0]      wdata,
   output logic             wr,
   output logic             rd,
   output logic             priv,
   input  wire logic [31:0] rdata
);
   import ebp_pkg::*;
   initial begin
      addr = 8'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      priv = 1'b1;
   end
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg
   task automatic set_priv(input logic p);
      @(posedge clk);
      priv <= p;
   endtask : set_priv
   // words are never all ones, so every pushed word counts
   task automatic push_pw(input logic [31:0] w, input int n);
      for (int i = 0; i < n; i++) wr_reg(REG_PW, w + i[31:0]);
   endtask : push_pw
   // polls the working flag for at most 64 status reads; ok is set only if it cleared
   task automatic wait_idle(output logic ok);
      logic [31:0] s;
      ok = 1'b0;
      for (int i = 0; i < 64 && !ok; i++) begin
         rd_reg(REG_STATUS, s);
         ok = (s[ST_WORK_BIT] === 1'b0);
      end
   endtask : wait_idle
endmodule : ebp_host_model
`default_nettype wire

// ==== tb/eeprom_block_protection_tb.sv ====
// self-checking bench for the eeprom block protection logic
`timescale 1ns/100ps
`default_nettype none
module eeprom_block_protection_tb;
   import ebp_pkg::*;
   logic        clk;
   logic        rst_n;
   logic        init_fail;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic        priv;
   logic [31:0] rdata;
   logic        irq;
   logic [31:0] v;
   logic        ok;
   int          miscompares = 0;
   int          cmp_count = 0;
   logic [1:0]  nopw[3] = '{2'h3, 2'h0, 2'h1};
   logic [1:0]  unl[3]  = '{2'h3, 2'h3, 2'h1};
   logic [1:0]  lck[3]  = '{2'h1, 2'h0, 2'h0};

   ebp_top #(.NBLK(NUM_BLOCKS)) uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .priv(priv), .init_fail(init_fail), .rdata(rdata), .irq(irq));
   ebp_host_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .priv(priv), .rdata(rdata));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic print_verdict;
      if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic do_reset(input logic fail);
      @(posedge clk);
      rst_n <= 1'b0;
      init_fail <= fail;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
   endtask : do_reset

   task automatic sel(input int b, input logic [7:0] a, input logic [31:0] d);
      host.wr_reg(REG_BLOCK, b[31:0]);
      host.wr_reg(a, d);
      if (a == REG_PROT) host.wait_idle(ok);
   endtask : sel

   // access check result: bit1 write allowed, bit0 read allowed
   task automatic acc(input int b, input logic [1:0] exp);
      sel(b, REG_CHECK, 32'h1);
      host.rd_reg(REG_CHECK, v);
      chk({30'h0, v[1:0]}, {30'h0, exp});
   endtask : acc

   task automatic set_pw(input int b, input logic [31:0] w, input int n);
      host.wr_reg(REG_BLOCK, b[31:0]);
      host.push_pw(w, n);
      host.wr_reg(REG_CMD, 32'h4);
      host.wait_idle(ok);
   endtask : set_pw

   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      print_verdict();
   end

   initial begin
      rst_n = 1'b0;
      init_fail = 1'b0;
      do_reset(1'b0);
      host.rd_reg(REG_INIT, v);
      chk(v, 32'h0);
      for (int b = 1; b < 4; b++) sel(b, REG_PROT, b - 1);
      for (int b = 1; b < 4; b++) acc(b, nopw[b-1]);
      for (int b = 1; b < 4; b++) set_pw(b, 32'h1000_0000 + b, 1);
      for (int b = 1; b < 4; b++) acc(b, unl[b-1]);
      for (int b = 1; b < 4; b++) sel(b, REG_CMD, 32'h1);
      for (int b = 1; b < 4; b++) acc(b, lck[b-1]);
      host.push_pw(32'h0bad_0001, 1);
      host.wr_reg(REG_UNLOCK, 32'h0);
      host.rd_reg(REG_UNLOCK, v);
      chk(v & 32'h1, 32'h0);
      acc(3, 2'h0);
      host.wr_reg(REG_PW, 32'hffff_ffff);
      host.push_pw(32'h1000_0003, 1);
      host.wr_reg(REG_UNLOCK, 32'h0);
      host.rd_reg(REG_UNLOCK, v);
      chk(v & 32'h1, 32'h1);
      acc(3, 2'h1);
      acc(2, 2'h0);
      host.wr_reg(REG_STATUS, 32'h2);
      host.rd_reg(REG_STATUS, v);
      chk(v & 32'h2, 32'h0);
      set_pw(3, 32'h2000_0000, 1);
      host.rd_reg(REG_STATUS, v);
      chk(v & 32'h2, 32'h2);
      host.wr_reg(REG_STATUS, 32'h2);
      host.rd_reg(REG_STATUS, v);
      chk(v & 32'h2, 32'h0);
      // block 0 flags are OR-ed into block 1
      do_reset(1'b0);
      sel(1, REG_PROT, 32'h8);
      sel(0, REG_PROT, 32'h2);
      acc(1, 2'h1);
      host.set_priv(1'b0);
      acc(1, 2'h0);
      host.set_priv(1'b1);
      do_reset(1'b1);
      host.rd_reg(REG_INIT, v);
      chk(v, 32'h1);
      sel(1, REG_PROT, 32'h1);
      set_pw(0, 32'h0000_00a5, 2);
      sel(0, REG_CMD, 32'h1);
      sel(1, REG_BLOCK, 32'h1);
      host.rd_reg(REG_PROT, v);
      chk(v, 32'h0);
      acc(1, 2'h0);
      host.wr_reg(REG_BLOCK, 32'h0);
      host.push_pw(32'h0000_00a5, 2);
      host.wr_reg(REG_UNLOCK, 32'h0);
      sel(1, REG_BLOCK, 32'h1);
      host.rd_reg(REG_PROT, v);
      chk(v, 32'h1);
      sel(2, REG_PROT, 32'h2);
      host.wr_reg(REG_CMD, 32'h2);
      host.rd_reg(REG_PROT, v);
      chk(v, 32'h0);
      acc(2, 2'h0);
      host.wr_reg(REG_CHECK, 32'h0);
      host.rd_reg(REG_CHECK, v);
      chk(v, 32'h0);
      host.wr_reg(REG_INT_RAW, 32'h1);
      sel(0, REG_INT_MASK, 32'h1);
      host.wr_reg(REG_CMD, 32'h8);
      host.rd_reg(REG_STATUS, v);
      chk(v & 32'h1c, 32'h14);
      host.wr_reg(REG_CHECK, 32'h0);
      host.rd_reg(REG_STATUS, v);
      chk(v & 32'h1, 32'h1);
      host.wr_reg(REG_PROT, 32'h0);
      host.rd_reg(REG_STATUS, v);
      chk(v & 32'h2, 32'h2);
      repeat (8) @(posedge clk);
      host.rd_reg(REG_STATUS, v);
      chk(v & 32'h1c, 32'h18);
      host.wait_idle(ok);
      chk({31'h0, ok}, 32'h1);
      host.rd_reg(REG_INT_RAW, v);
      chk(v & 32'h1, 32'h1);
      chk({31'h0, irq}, 32'h1);
      host.wr_reg(REG_INT_MASK, 32'h0);
      host.rd_reg(REG_INT_MSK_ST, v);
      chk(v & 32'h1, 32'h0);
      chk({31'h0, irq}, 32'h0);
      host.wr_reg(REG_INT_MASK, 32'h1);
      host.wr_reg(REG_INT_RAW, 32'h1);
      host.rd_reg(REG_INT_RAW, v);
      chk(v & 32'h1, 32'h0);
      print_verdict();
   end
endmodule : eeprom_block_protection_tb
`default_nettype wire
